// >>> tb.sv
/*
  Self-checking bench for the capture/reload timer through its SFR port.
  Assumes tcr_pkg addresses and the far-side model tcr_pins.
*/
`timescale 1ns/1ps
module tb;
  import tcr_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic [7:0] sfr_wdata = 8'h00;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic [7:0] sfr_rdata;
  logic prescale_select = 1'b0;
  logic timer_irq_enable = 1'b0;
  logic timer1_overflow, external_count_pin, trigger_pin;
  logic timer_irq, uart_rx_shift_clock, uart_tx_shift_clock, adc_start_trigger;
  int num_errors = 0;
  int n_tests = 0;
  int cyc = 0;
  int r0, t0, a0;

  always #12.5 clk = ~clk;

  tcr_timer i_tcr_timer (.clk(clk), .nrst(nrst), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .prescale_select(prescale_select),
    .timer_irq_enable(timer_irq_enable), .timer1_overflow(timer1_overflow),
    .external_count_pin(external_count_pin), .trigger_pin(trigger_pin), .timer_irq(timer_irq),
    .uart_rx_shift_clock(uart_rx_shift_clock), .uart_tx_shift_clock(uart_tx_shift_clock),
    .adc_start_trigger(adc_start_trigger));
  tcr_pins i_tcr_pins (.clk(clk), .external_count_pin(external_count_pin), .trigger_pin(trigger_pin),
    .timer1_overflow(timer1_overflow), .uart_rx_shift_clock(uart_rx_shift_clock),
    .uart_tx_shift_clock(uart_tx_shift_clock), .adc_start_trigger(adc_start_trigger));

  // ----------------------------------------------------------------
  // Access and compare tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clk);
    sfr_wr = 1'b0;
  endtask : wr

  task automatic rd_raw(input logic [7:0] a);
    @(negedge clk);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge clk);
    sfr_rd = 1'b0;
    @(negedge clk);
  endtask : rd_raw

  task automatic rd(input string nm, input logic [7:0] a, input logic [7:0] e);
    rd_raw(a);
    chk(nm, e, sfr_rdata);
  endtask : rd

  task automatic rd_rng(input string nm, input logic [7:0] lo, input logic [7:0] hi);
    rd_raw(ADDR_CNT_LO);
    n_tests++;
    if ($isunknown(sfr_rdata) || sfr_rdata < lo || sfr_rdata > hi) begin
      num_errors++;
      $display("mismatch %s expected %0d to %0d seen %0d", nm, lo, hi, sfr_rdata);
    end
  endtask : rd_rng

  task automatic timed(input string nm, input logic [7:0] ctl, input int n, input logic [7:0] lo,
                       input logic [7:0] hi);
    wr(ADDR_CONTROL, 8'h00);
    wr(ADDR_CNT_LO, 8'h00);
    wr(ADDR_CNT_HI, 8'h00);
    wr(ADDR_CONTROL, ctl);
    repeat (n) @(negedge clk);
    rd_rng(nm, lo, hi);
  endtask : timed

  task automatic results();
    $display("tests %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : results

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      num_errors++;
      results();
    end
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    rd("ctl", ADDR_CONTROL, 8'h00);
    rd("unmapped", 8'hc9, READ_UNMAPPED);
    wr(ADDR_CAP_LO, 8'h34);
    wr(ADDR_CAP_HI, 8'h12);
    rd("caplo", ADDR_CAP_LO, 8'h34);
    $display("test reset done");
    wr(ADDR_CONTROL, 8'h0b);
    i_tcr_pins.fall(1'b0, 3);
    rd("stopped", ADDR_CNT_LO, 8'h00);
    wr(ADDR_CONTROL, 8'h0f);
    i_tcr_pins.fall(1'b0, 5);
    rd("cntlo", ADDR_CNT_LO, 8'h05);
    i_tcr_pins.fall(1'b1, 1);
    rd("caplo", ADDR_CAP_LO, 8'h05);
    rd("caphi", ADDR_CAP_HI, 8'h00);
    rd("ctl", ADDR_CONTROL, 8'h4f);
    chk("irq off", 8'h00, {7'h00, timer_irq});
    timer_irq_enable = 1'b1;
    @(negedge clk);
    chk("irq on", 8'h01, {7'h00, timer_irq});
    wr(ADDR_CONTROL, 8'h07);
    wr(ADDR_CNT_LO, 8'h09);
    i_tcr_pins.fall(1'b1, 1);
    rd("caplo", ADDR_CAP_LO, 8'h05);
    rd("ctl", ADDR_CONTROL, 8'h07);
    $display("test capture done");
    wr(ADDR_CAP_LO, 8'h34);
    wr(ADDR_CAP_HI, 8'h12);
    wr(ADDR_CNT_LO, 8'hff);
    wr(ADDR_CNT_HI, 8'hff);
    wr(ADDR_CONTROL, 8'h0e);
    a0 = i_tcr_pins.adc_n;
    i_tcr_pins.fall(1'b0, 1);
    rd("cnthi", ADDR_CNT_HI, 8'h12);
    rd("cntlo", ADDR_CNT_LO, 8'h34);
    rd("ctl", ADDR_CONTROL, 8'h8e);
    chk("adc", 8'h01, 8'(i_tcr_pins.adc_n - a0));
    i_tcr_pins.fall(1'b0, 2);
    i_tcr_pins.fall(1'b1, 1);
    rd("cntlo", ADDR_CNT_LO, 8'h34);
    repeat (20) @(negedge clk);
    rd("ctl", ADDR_CONTROL, 8'hce);
    wr(ADDR_CONTROL, 8'h0e);
    rd("ctl", ADDR_CONTROL, 8'h0e);
    $display("test reload done");
    wr(ADDR_CNT_LO, 8'hff);
    wr(ADDR_CNT_HI, 8'hff);
    wr(ADDR_CONTROL, 8'h1f);
    r0 = i_tcr_pins.rx_n;
    t0 = i_tcr_pins.tx_n;
    i_tcr_pins.fall(1'b0, 1);
    rd("cntlo", ADDR_CNT_LO, 8'h34);
    rd("ctl", ADDR_CONTROL, 8'h1f);
    chk("tx", 8'h01, 8'(i_tcr_pins.tx_n - t0));
    i_tcr_pins.t1_pulse();
    chk("rx", 8'h01, 8'(i_tcr_pins.rx_n - r0));
    chk("tx", 8'h01, 8'(i_tcr_pins.tx_n - t0));
    i_tcr_pins.fall(1'b1, 1);
    rd("ctl", ADDR_CONTROL, 8'h5f);
    rd("cnthi", ADDR_CNT_HI, 8'h12);
    $display("test baud done");
    timed("div12", 8'h04, 120, 8'h09, 8'h0b);
    wr(ADDR_CONTROL, 8'h00);
    prescale_select = 1'b1;
    timed("div1", 8'h04, 40, 8'h26, 8'h2c);
    timed("div2", 8'h14, 40, 8'h12, 8'h17);
    $display("test timebase done");
    results();
  end
endmodule : tb

// >>> tcr_pins.sv
/*
  Far-side model: drives the count and trigger pins, pulses Timer 1 overflow,
  counts routed UART shift-clock and conversion-start pulses.
  Assumes inputs change at the falling edge of clk.
*/
`timescale 1ns/1ps
module tcr_pins (
  input wire logic clk,
  output logic external_count_pin,
  output logic trigger_pin,
  output logic timer1_overflow,
  input wire logic uart_rx_shift_clock,
  input wire logic uart_tx_shift_clock,
  input wire logic adc_start_trigger
);
  int rx_n = 0;
  int tx_n = 0;
  int adc_n = 0;

  initial begin
    external_count_pin = 1'b1;
    trigger_pin = 1'b1;
    timer1_overflow = 1'b0;
  end

  always @(posedge clk) begin
    rx_n <= rx_n + int'(uart_rx_shift_clock);
    tx_n <= tx_n + int'(uart_tx_shift_clock);
    adc_n <= adc_n + int'(adc_start_trigger);
  end

  // ----------------------------------------------------------------
  // Pin falls, low held two samples, high at least three
  // ----------------------------------------------------------------
  task automatic fall(input bit trig, input int n);
    repeat (n) begin
      @(negedge clk);
      if (trig) begin
        trigger_pin = 1'b0;
      end else begin
        external_count_pin = 1'b0;
      end
      repeat (2) @(negedge clk);
      trigger_pin = 1'b1;
      external_count_pin = 1'b1;
      repeat (2) @(negedge clk);
    end
    repeat (4) @(negedge clk);
  endtask : fall

  task automatic t1_pulse();
    @(negedge clk);
    timer1_overflow = 1'b1;
    @(negedge clk);
    timer1_overflow = 1'b0;
    repeat (2) @(negedge clk);
  endtask : t1_pulse
endmodule : tcr_pins

// >>> tcr_pkg.sv
/*
  Constants, state layout and mode decoding for the 16-bit capture/reload timer.
  Assumes an 8-bit special-function-register port and a 40 MHz system clock.
*/
package tcr_pkg;

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CONTROL = 8'hc8;
  localparam logic [7:0] ADDR_CAP_LO = 8'hca;
  localparam logic [7:0] ADDR_CAP_HI = 8'hcb;
  localparam logic [7:0] ADDR_CNT_LO = 8'hcc;
  localparam logic [7:0] ADDR_CNT_HI = 8'hcd;

  // ----------------------------------------------------------------
  // Control field positions
  // ----------------------------------------------------------------
  localparam int BIT_OVERFLOW_FLAG = 7;
  localparam int BIT_EXTERNAL_FLAG = 6;
  localparam int BIT_RX_CLOCK_SELECT = 5;
  localparam int BIT_TX_CLOCK_SELECT = 4;
  localparam int BIT_EXT_ENABLE = 3;
  localparam int BIT_RUN = 2;
  localparam int BIT_COUNTER_SELECT = 1;
  localparam int BIT_CAPTURE_SELECT = 0;

  // ----------------------------------------------------------------
  // Reset values and counts
  // ----------------------------------------------------------------
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;
  localparam logic [15:0] COUNT_MAX = 16'hffff;
  localparam logic [15:0] COUNT_ZERO = 16'h0000;
  localparam logic [15:0] COUNT_ONE = 16'h0001;
  localparam int CLK_PERIOD_NS = 25;
  localparam int PRESCALE_DIVISOR = 12;
  localparam logic [3:0] PRESCALE_LAST = 4'(PRESCALE_DIVISOR - 1);
  localparam logic [3:0] PRESCALE_FIRST = 4'h0;
  localparam logic [3:0] PRESCALE_STEP = 4'h1;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    MODE_OFF = 4'b0001,
    MODE_CAPTURE = 4'b0010,
    MODE_RELOAD = 4'b0100,
    MODE_BAUD = 4'b1000
  } tcr_mode_type;

  typedef struct packed {
    logic [7:0] control;
    logic [15:0] count;
    logic [15:0] capture;
    logic [3:0] presc;
    logic half;
    logic cnt_s1;
    logic cnt_s2;
    logic cnt_prev;
    logic trg_s1;
    logic trg_s2;
    logic trg_prev;
    logic [7:0] rdata;
    logic rx_pulse;
    logic tx_pulse;
    logic adc_pulse;
  } tcr_state_type;

  localparam tcr_state_type STATE_RESET = '0;

  function automatic tcr_mode_type tcr_mode(input logic [7:0] ctl);
    if (!ctl[BIT_RUN]) begin
      return MODE_OFF;
    end else if (ctl[BIT_RX_CLOCK_SELECT] || ctl[BIT_TX_CLOCK_SELECT]) begin
      return MODE_BAUD;
    end else if (ctl[BIT_CAPTURE_SELECT]) begin
      return MODE_CAPTURE;
    end else begin
      return MODE_RELOAD;
    end
  endfunction : tcr_mode

endpackage : tcr_pkg

// >>> tcr_timer.sv
/*
  16-bit counter/timer with capture, auto-reload and baud-rate generator modes.
  Assumes a synchronous SFR port from the CPU and synchronous-style pin inputs;
  the UART divides the routed shift-clock pulses further.
*/
`timescale 1ns/1ps
// Overview of operation
// R01 - Count is 16 bits from two bytes
// R02 - Select bit picks prescaled clock or pin falls
// R03 - Timer clock: divide by 12 or undivided
// R04 - Clock select ignored in baud or counter
// R05 - Mode from run, UART selects, capture bit
// R06 - Trigger fall copies count into capture pair
// R07 - Trigger ignored while external enable clear
// R08 - Overflow flag on rollover in capture/reload
// R09 - Reload mode overflow loads capture pair
// R10 - Reload mode trigger fall also reloads count
// R11 - External flag on trigger capture or reload
// R12 - Baud overflow reloads, pulses UART, no flag
// R13 - UART selects force auto-reload behaviour
// R14 - Select bits route this timer or Timer 1
// R15 - Baud equals overflow rate over sixteen
// R16 - Baud mode counts system clock halves
// R17 - External baud: pin over 16 times span
// R18 - Baud mode trigger only sets external flag
// R19 - Flags cleared only by software writes
// R20 - Interrupt while flag set and enabled
// R21 - Run bit clear stops counting
// R22 - Overflow offered as conversion start trigger
// R23 - Control register resets to zero
// R24 - Pins synchronised, falls detected
module tcr_timer
  import tcr_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  output logic [7:0] sfr_rdata,
  input wire logic prescale_select,
  input wire logic timer_irq_enable,
  input wire logic timer1_overflow,
  input wire logic external_count_pin,
  input wire logic trigger_pin,
  output logic timer_irq,
  output logic uart_rx_shift_clock,
  output logic uart_tx_shift_clock,
  output logic adc_start_trigger
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  tcr_state_type state_ff;
  tcr_state_type nxt_state;
  tcr_mode_type mode;
  logic cnt_fall;
  logic trg_fall;
  logic tick;
  logic overflow;
  logic trig_act;
  logic baud_sel;
  logic div12_tick;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    mode = tcr_mode(state_ff.control); // see R05
    baud_sel = state_ff.control[BIT_RX_CLOCK_SELECT] | state_ff.control[BIT_TX_CLOCK_SELECT];
    // Pin synchronisers and fall detection
    nxt_state.cnt_s1 = external_count_pin; // see R24
    nxt_state.cnt_s2 = state_ff.cnt_s1;
    nxt_state.cnt_prev = state_ff.cnt_s2;
    nxt_state.trg_s1 = trigger_pin;
    nxt_state.trg_s2 = state_ff.trg_s1;
    nxt_state.trg_prev = state_ff.trg_s2;
    cnt_fall = state_ff.cnt_prev & ~state_ff.cnt_s2; // see R24
    trg_fall = state_ff.trg_prev & ~state_ff.trg_s2;
    // Prescalers
    div12_tick = (state_ff.presc == PRESCALE_LAST);
    if (div12_tick) begin
      nxt_state.presc = PRESCALE_FIRST;
    end else begin
      nxt_state.presc = state_ff.presc + PRESCALE_STEP;
    end
    nxt_state.half = ~state_ff.half;
    // Count source
    case (mode)
      MODE_OFF: begin
        tick = 1'b0; // see R21
      end
      MODE_BAUD: begin
        // Prescale select ignored here
        tick = state_ff.control[BIT_COUNTER_SELECT] ? cnt_fall : state_ff.half; // see R16, R04, R17
      end
      default: begin
        if (state_ff.control[BIT_COUNTER_SELECT]) begin
          tick = cnt_fall; // see R02, R04
        end else begin
          tick = prescale_select ? 1'b1 : div12_tick; // see R03
        end
      end
    endcase
    overflow = tick && (state_ff.count == COUNT_MAX);
    trig_act = trg_fall && state_ff.control[BIT_EXT_ENABLE]; // see R07
    // Count update
    if (overflow) begin
      if (mode == MODE_CAPTURE) begin
        nxt_state.count = COUNT_ZERO;
      end else begin
        nxt_state.count = state_ff.capture; // see R09, R12, R13
      end
    end else if (tick) begin
      nxt_state.count = state_ff.count + COUNT_ONE;
    end
    if (trig_act && !baud_sel && !state_ff.control[BIT_CAPTURE_SELECT]) begin
      nxt_state.count = state_ff.capture; // see R10
    end
    // Software writes to count, capture and control bytes
    if (sfr_wr) begin
      if (sfr_addr == ADDR_CNT_LO) begin
        nxt_state.count[7:0] = sfr_wdata; // see R01
      end else if (sfr_addr == ADDR_CNT_HI) begin
        nxt_state.count[15:8] = sfr_wdata; // see R01
      end else if (sfr_addr == ADDR_CAP_LO) begin
        nxt_state.capture[7:0] = sfr_wdata;
      end else if (sfr_addr == ADDR_CAP_HI) begin
        nxt_state.capture[15:8] = sfr_wdata;
      end else if (sfr_addr == ADDR_CONTROL) begin
        nxt_state.control = sfr_wdata; // see R19
      end
    end
    // Capture takes priority over a write in the same cycle
    if (trig_act && !baud_sel && state_ff.control[BIT_CAPTURE_SELECT]) begin
      nxt_state.capture = state_ff.count; // see R06
    end
    // Flag sets win over a clearing write
    if (overflow && !baud_sel) begin
      nxt_state.control[BIT_OVERFLOW_FLAG] = 1'b1; // see R08, R12
    end
    if (trig_act) begin
      nxt_state.control[BIT_EXTERNAL_FLAG] = 1'b1; // see R11, R18
    end
    // Read data
    if (sfr_rd) begin
      if (sfr_addr == ADDR_CONTROL) begin
        nxt_state.rdata = state_ff.control;
      end else if (sfr_addr == ADDR_CAP_LO) begin
        nxt_state.rdata = state_ff.capture[7:0];
      end else if (sfr_addr == ADDR_CAP_HI) begin
        nxt_state.rdata = state_ff.capture[15:8];
      end else if (sfr_addr == ADDR_CNT_LO) begin
        nxt_state.rdata = state_ff.count[7:0];
      end else if (sfr_addr == ADDR_CNT_HI) begin
        nxt_state.rdata = state_ff.count[15:8];
      end else begin
        nxt_state.rdata = READ_UNMAPPED;
      end
    end
    // Shift-clock routing; UART divides by sixteen
    nxt_state.rx_pulse = state_ff.control[BIT_RX_CLOCK_SELECT] ? overflow : timer1_overflow; // see R14, R15
    nxt_state.tx_pulse = state_ff.control[BIT_TX_CLOCK_SELECT] ? overflow : timer1_overflow; // see R14, R15
    nxt_state.adc_pulse = overflow; // see R22
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_ff <= STATE_RESET; // see R23
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign sfr_rdata = state_ff.rdata;
  assign timer_irq = timer_irq_enable
    && (state_ff.control[BIT_OVERFLOW_FLAG] || state_ff.control[BIT_EXTERNAL_FLAG]); // see R20
  assign uart_rx_shift_clock = state_ff.rx_pulse;
  assign uart_tx_shift_clock = state_ff.tx_pulse;
  assign adc_start_trigger = state_ff.adc_pulse;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic ctl_wr;
  logic cnt_wr;
  assign ctl_wr = sfr_wr && (sfr_addr == ADDR_CONTROL);
  assign cnt_wr = sfr_wr && ((sfr_addr == ADDR_CNT_LO) || (sfr_addr == ADDR_CNT_HI));

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  sequence ovf_in_flag_mode_s;
    overflow && ((mode == MODE_CAPTURE) || (mode == MODE_RELOAD));
  endsequence

  sequence prescaled_tick_s;
    (mode == MODE_RELOAD) && !state_ff.control[BIT_COUNTER_SELECT] && !prescale_select && tick;
  endsequence

  sequence quiet_s;
    !ctl_wr && !cnt_wr && !sfr_wr;
  endsequence

  sequence cnt_pin_fell_s;
    $fell(external_count_pin);
  endsequence

  sequence trg_pin_fell_s;
    $fell(trigger_pin);
  endsequence

  overflow_flag_set_a: assert property (ovf_in_flag_mode_s |=> state_ff.control[BIT_OVERFLOW_FLAG]) // see R08
    else $error("overflow flag not set after rollover");

  baud_no_flag_a: assert property (((mode == MODE_BAUD) && !state_ff.control[BIT_OVERFLOW_FLAG]) and quiet_s // see R12
    |=> !state_ff.control[BIT_OVERFLOW_FLAG])
    else $error("overflow flag set in baud mode");

  reload_on_overflow_a: assert property ((overflow && (mode != MODE_CAPTURE) && !trig_act) and quiet_s // see R09
    |=> state_ff.count == $past(state_ff.capture))
    else $error("count not reloaded on overflow");

  capture_copy_a: assert property (trig_act && (mode == MODE_CAPTURE) // see R06
    |=> state_ff.capture == $past(state_ff.count))
    else $error("capture pair missed the count");

  trigger_ignored_a: assert property ((trg_fall && !state_ff.control[BIT_EXT_ENABLE]) and quiet_s // see R07
    |=> $stable(state_ff.control[BIT_EXTERNAL_FLAG]) && $stable(state_ff.capture))
    else $error("trigger acted while disabled");

  ext_flag_set_a: assert property (trig_act |=> state_ff.control[BIT_EXTERNAL_FLAG]) // see R11
    else $error("external flag not set by trigger");

  flags_hold_a: assert property (quiet_s and state_ff.control[BIT_OVERFLOW_FLAG] // see R19
    |=> state_ff.control[BIT_OVERFLOW_FLAG])
    else $error("overflow flag cleared without a write");

  irq_follows_a: assert property (timer_irq // see R20
    |-> timer_irq_enable && (state_ff.control[BIT_OVERFLOW_FLAG] || state_ff.control[BIT_EXTERNAL_FLAG]))
    else $error("interrupt without enabled flag");

  stopped_count_a: assert property (((mode == MODE_OFF) && !trg_fall) and quiet_s // see R21
    |=> $stable(state_ff.count))
    else $error("count moved while stopped");

  div_twelve_a: assert property (disable iff (!nrst || ctl_wr) prescaled_tick_s // see R03
    |=> !tick [*8] ##1 !tick ##1 !tick ##1 !tick ##1 tick)
    else $error("prescaled tick spacing not twelve");

  baud_half_a: assert property ((mode == MODE_BAUD) && !state_ff.control[BIT_COUNTER_SELECT] && tick // see R16
    && $stable(state_ff.control) |=> !tick)
    else $error("baud tick faster than half rate");

  control_reset_a: assert property (disable iff (1'b0) !nrst |=> state_ff.control == CONTROL_RESET) // see R23
    else $error("control not cleared by reset");

  cnt_sync_fall_a: assert property (cnt_pin_fell_s |=> ##1 cnt_fall) // see R24
    else $error("count pin fall not detected");

  trg_sync_fall_a: assert property (trg_pin_fell_s |=> ##1 trg_fall) // see R24
    else $error("trigger pin fall not detected");

  count_step_a: assert property ((tick && !overflow && !trig_act) and quiet_s // see R02
    |=> state_ff.count == $past(state_ff.count) + COUNT_ONE)
    else $error("count did not advance by one");

  pin_tick_a: assert property ((mode != MODE_OFF) && state_ff.control[BIT_COUNTER_SELECT] // see R02, R04
    |-> tick == cnt_fall)
    else $error("pin falls not used as count source");

  undivided_tick_a: assert property ((mode inside {MODE_CAPTURE, MODE_RELOAD}) && prescale_select // see R03
    && !state_ff.control[BIT_COUNTER_SELECT] |-> tick)
    else $error("undivided clock not counted");

  off_no_tick_a: assert property ((mode == MODE_OFF) |-> !tick) // see R21
    else $error("tick while stopped");

  baud_half_src_a: assert property ((mode == MODE_BAUD) && !state_ff.control[BIT_COUNTER_SELECT] // see R16, R04
    |-> tick == state_ff.half)
    else $error("baud tick not from half rate");

  cap_ovf_zero_a: assert property ((overflow && (mode == MODE_CAPTURE)) and quiet_s // see R08
    |=> state_ff.count == COUNT_ZERO)
    else $error("capture mode rollover not to zero");

  trig_reload_a: assert property ((trig_act && !baud_sel // see R10
    && !state_ff.control[BIT_CAPTURE_SELECT]) and quiet_s |=> state_ff.count == $past(state_ff.capture))
    else $error("trigger did not reload count");

  baud_trig_keep_a: assert property ((trig_act && baud_sel && !tick) and quiet_s // see R18
    |=> $stable(state_ff.count) && $stable(state_ff.capture))
    else $error("baud trigger moved count or capture");

  capture_hold_a: assert property ((!trig_act) and quiet_s |=> $stable(state_ff.capture)) // see R06, R09
    else $error("capture pair changed without cause");

  ext_flag_hold_a: assert property (quiet_s and state_ff.control[BIT_EXTERNAL_FLAG] // see R19
    |=> state_ff.control[BIT_EXTERNAL_FLAG])
    else $error("external flag cleared without a write");

  ovf_flag_cause_a: assert property ((!state_ff.control[BIT_OVERFLOW_FLAG] && !(overflow && !baud_sel)) // see R08, R12
    and quiet_s |=> !state_ff.control[BIT_OVERFLOW_FLAG])
    else $error("overflow flag set without rollover");

  rx_timer_route_a: assert property (state_ff.control[BIT_RX_CLOCK_SELECT] // see R14
    |=> uart_rx_shift_clock == $past(overflow))
    else $error("receive clock not from this timer");

  rx_t1_route_a: assert property (!state_ff.control[BIT_RX_CLOCK_SELECT] // see R14
    |=> uart_rx_shift_clock == $past(timer1_overflow))
    else $error("receive clock not from the other timer");

  tx_timer_route_a: assert property (state_ff.control[BIT_TX_CLOCK_SELECT] // see R14
    |=> uart_tx_shift_clock == $past(overflow))
    else $error("transmit clock not from this timer");

  tx_t1_route_a: assert property (!state_ff.control[BIT_TX_CLOCK_SELECT] // see R14
    |=> uart_tx_shift_clock == $past(timer1_overflow))
    else $error("transmit clock not from the other timer");

  adc_pulse_a: assert property (overflow |=> adc_start_trigger) // see R22
    else $error("conversion start missed overflow");

  adc_quiet_a: assert property (!overflow |=> !adc_start_trigger) // see R22
    else $error("conversion start without overflow");

  rdata_hold_a: assert property (!sfr_rd |=> $stable(sfr_rdata)) // see R01
    else $error("read data changed without a read");

  rd_count_lo_a: assert property (sfr_rd && (sfr_addr == ADDR_CNT_LO) // see R01
    |=> sfr_rdata == $past(state_ff.count[7:0]))
    else $error("count low byte read wrong");

  wr_count_lo_a: assert property (sfr_wr && (sfr_addr == ADDR_CNT_LO) // see R01
    |=> state_ff.count[7:0] == $past(sfr_wdata))
    else $error("count low byte write lost");

  wr_count_hi_a: assert property (sfr_wr && (sfr_addr == ADDR_CNT_HI) // see R01
    |=> state_ff.count[15:8] == $past(sfr_wdata))
    else $error("count high byte write lost");

  irq_raise_a: assert property (timer_irq_enable && state_ff.control[BIT_EXTERNAL_FLAG] |-> timer_irq) // see R20
    else $error("interrupt missing for external flag");

  mode_baud_a: assert property (state_ff.control[BIT_RUN] && baud_sel |-> (mode == MODE_BAUD)) // see R05, R13
    else $error("UART select did not force reload behaviour");

endmodule : tcr_timer
